/* hw/swl_slave.sv */
`timescale 1ns/1ps
module swl_slave (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	// Link pin
	input wire logic master_voltage_signal,
	output logic slave_current_signal,
	// Transmit byte stream
	input wire swl_pkg::byte_t tx_in,
	input wire logic tx_last,
	output logic tx_ready,
	// Receive byte stream
	output swl_pkg::byte_t rx_out,
	// Status
	output logic line_high
);
	swl_pkg::link_state_t st;
	swl_pkg::link_state_t next_st;
	logic rise;
	logic fall;
	logic bit_in;
	logic [7:0] tx_byte;

	swl_edge edge_u (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.sync(st.sync),
		.line(st.line),
		.rise(rise),
		.fall(fall)
	);

	assign bit_in = (st.hi_cnt > swl_pkg::CNT_W'(swl_pkg::ZERO_HIGH_CYC)); // R8

	always_comb begin
		next_st = st;
		next_st.sync = {st.sync[1:0], master_voltage_signal}; // R3
		tx_byte = tx_in.valid ? tx_in.data : swl_pkg::RESERVED_BYTE; // R1
		next_st.rx_out.valid = 1'b0;
		next_st.tx_ready = 1'b0;
		if (rise) begin
			next_st.line = 1'b1;
			next_st.hi_cnt = '0;
		end else if (fall) begin
			next_st.line = 1'b0;
			// Last frame bit drops its draw once the line goes low
			if (st.tx_state == swl_pkg::TX_IDLE) begin
				next_st.draw = 1'b0; // R13
			end
			// Bit decoded on falling edge, b8 first
			next_st.rx_sh = {st.rx_sh[6:0], bit_in}; // R2
			next_st.rx_bits = st.rx_bits + 3'h1;
			if (st.rx_bits == 3'h7) begin
				next_st.rx_out.data = {st.rx_sh[6:0], bit_in};
				next_st.rx_out.valid = 1'b1;
			end
		end else if (st.line && st.hi_cnt != '1) begin
			next_st.hi_cnt = st.hi_cnt + swl_pkg::CNT_W'(1);
		end
		// Transmit bit advances on rising edge, inside high phase
		if (rise) begin // R15
			unique case (st.tx_state)
				swl_pkg::TX_IDLE: begin
					next_st.draw = 1'b0; // R13
					if (tx_in.valid) begin
						next_st.tx_state = swl_pkg::TX_WAKE; // R14
						next_st.tx_cnt = 4'(swl_pkg::WAKEUP_BITS - 1);
						next_st.draw = 1'b1;
					end
				end
				swl_pkg::TX_WAKE: begin
					// Alternating draw marks the start of our frame
					next_st.draw = ~st.draw; // R14
					if (st.tx_cnt == 4'h1) begin
						// Last wakeup bit; the next rise takes the first byte
						next_st.tx_state = swl_pkg::TX_DATA;
						next_st.tx_cnt = 4'h8;
					end else begin
						next_st.tx_cnt = st.tx_cnt - 4'h1;
					end
				end
				swl_pkg::TX_DATA: begin
					if (st.tx_cnt == 4'h8) begin
						// Byte taken on the rise that sends its b8
						next_st.draw = tx_byte[7]; // R2 R6
						next_st.tx_sh = {tx_byte[6:0], 1'b0};
						next_st.tx_cnt = 4'h6;
						next_st.tx_ready = 1'b1;
					end else begin
						next_st.draw = st.tx_sh[7]; // R2 R6
						next_st.tx_sh = {st.tx_sh[6:0], 1'b0};
						if (st.tx_cnt == 4'h0) begin
							if (tx_last || !tx_in.valid) begin
								next_st.tx_state = swl_pkg::TX_IDLE; // R13
							end else begin
								next_st.tx_cnt = 4'h8;
							end
						end else begin
							next_st.tx_cnt = st.tx_cnt - 4'h1;
						end
					end
				end
			endcase
		end
	end

	// Only the link reset touches this state; other interfaces have no path here
	always_ff @(posedge clk_sys or negedge rst_b) begin // R9 R11 R12
		if (!rst_b) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// Current drawn only while line is high, never voltage driven
	assign slave_current_signal = st.draw & st.line; // R5 R7 R10
	assign tx_ready = st.tx_ready;
	assign rx_out = st.rx_out;
	assign line_high = st.line;

	// Return path
	a_draw_needs_high: assert property (@(posedge clk_sys) disable iff (!rst_b) // R7
		slave_current_signal |-> line_high)
		else $error("current drawn while line low");

	a_current_no_drive: assert property (@(posedge clk_sys) disable iff (!rst_b) // R5
		slave_current_signal |-> st.draw)
		else $error("current without draw request");

	a_fall_clears: assert property (@(posedge clk_sys) disable iff (!rst_b) // R7
		(clk_en && fall) |=> !slave_current_signal)
		else $error("draw after fall");

	a_draw_stable_low: assert property (@(posedge clk_sys) disable iff (!rst_b) // R15
		(!line_high && !rise) |=> $stable(st.draw))
		else $error("draw changed in low phase");

	// Transmit sequence
	a_idle_no_draw: assert property (@(posedge clk_sys) disable iff (!rst_b) // R13
		(st.tx_state == swl_pkg::TX_IDLE && !line_high) |-> !st.draw)
		else $error("current drawn while idle");

	a_idle_rise_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b) // R13
		(rise && st.tx_state == swl_pkg::TX_IDLE && !tx_in.valid) |=> !st.draw)
		else $error("idle bit not zero");

	a_wake_first: assert property (@(posedge clk_sys) disable iff (!rst_b) // R14
		(st.tx_state == swl_pkg::TX_DATA) |-> $past(st.tx_state == swl_pkg::TX_WAKE
		|| st.tx_state == swl_pkg::TX_DATA))
		else $error("data without wakeup");

	a_wake_alternate: assert property (@(posedge clk_sys) disable iff (!rst_b) // R14
		(rise && st.tx_state == swl_pkg::TX_WAKE) |=> (st.draw != $past(st.draw)))
		else $error("wakeup bits not alternating");

	a_wake_to_data: assert property (@(posedge clk_sys) disable iff (!rst_b) // R14
		(rise && st.tx_state == swl_pkg::TX_WAKE && st.tx_cnt == 4'h1)
		|=> (st.tx_state == swl_pkg::TX_DATA && st.tx_cnt == 4'h8 && !st.draw))
		else $error("wakeup did not end in data");

	a_tx_msb_first: assert property (@(posedge clk_sys) disable iff (!rst_b) // R2
		(rise && st.tx_state == swl_pkg::TX_DATA && st.tx_cnt == 4'h8 && tx_in.valid)
		|=> (st.draw == $past(tx_in.data[7])))
		else $error("first sent bit is not b8");

	a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
		(rise && st.tx_state == swl_pkg::TX_DATA && st.tx_cnt == 4'h8 && !tx_in.valid)
		|=> (!st.draw && st.tx_sh == 8'h00))
		else $error("missing byte not sent as zero");

	a_ready_on_rise: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
		tx_ready |-> $past(rise))
		else $error("ready without rising edge");

	a_ready_in_data: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
		tx_ready |-> (st.tx_state == swl_pkg::TX_DATA && st.tx_cnt == 4'h6))
		else $error("ready outside byte load");

	a_frame_end: assert property (@(posedge clk_sys) disable iff (!rst_b) // R13
		(rise && st.tx_state == swl_pkg::TX_DATA && st.tx_cnt == 4'h0
		&& (tx_last || !tx_in.valid)) |=> (st.tx_state == swl_pkg::TX_IDLE))
		else $error("frame did not end");

	// Receive path
	a_rx_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b) // R2
		rx_out.valid |=> !rx_out.valid)
		else $error("receive valid held");

	a_rx_b8_first: assert property (@(posedge clk_sys) disable iff (!rst_b) // R2
		rx_out.valid |-> (rx_out.data == {$past(st.rx_sh[6:0]), $past(bit_in)}))
		else $error("received byte order wrong");

	a_hi_cnt_clear: assert property (@(posedge clk_sys) disable iff (!rst_b) // R8
		(clk_en && rise) |=> (st.hi_cnt == '0))
		else $error("high time not restarted");

	a_hi_cnt_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) // R8
		(st.line && st.hi_cnt == '1 && !rise && !fall) |=> (st.hi_cnt == '1))
		else $error("high time counter wrapped");

	// Sampling and clock enable
	a_line_follows: assert property (@(posedge clk_sys) disable iff (!rst_b) // R15
		(clk_en && rise) |=> line_high)
		else $error("line did not follow edge");

	a_sync_shift: assert property (@(posedge clk_sys) disable iff (!rst_b) // R15
		clk_en |=> (st.sync == {$past(st.sync[1:0]), $past(master_voltage_signal)}))
		else $error("line sampler did not shift");

	a_freeze_state: assert property (@(posedge clk_sys) disable iff (!rst_b) // R15
		!clk_en |=> $stable(st))
		else $error("state moved while frozen");

	c_wake: cover property (@(posedge clk_sys) st.tx_state == swl_pkg::TX_WAKE);
	c_rx_byte: cover property (@(posedge clk_sys) rx_out.valid);
	c_draw: cover property (@(posedge clk_sys) slave_current_signal);
	c_reserved: cover property (@(posedge clk_sys)
		rise && st.tx_state == swl_pkg::TX_DATA && st.tx_cnt == 4'h8 && !tx_in.valid);
	c_frame_end: cover property (@(posedge clk_sys)
		rise && st.tx_state == swl_pkg::TX_DATA && st.tx_cnt == 4'h0 && tx_last);
endmodule : swl_slave

/* hw/swl_pkg.sv */
// What this block does
// [R1] Reserved bytes and bits always sent as zero
// [R2] Bytes sent and received b8 first
// [R3] Frontend is sole master, we are slave
// [R4] Master modulates line voltage in two states
// [R5] We answer by drawing current, never driving
// [R6] Line high: draw current for one, none zero
// [R7] Return state meaningful only while line high
// [R8] Master pulse width carries clock and data
// [R9] Link runs concurrently with other card interfaces
// [R10] Link pin activity never touches other contacts
// [R11] Other interface resets leave link untouched
// [R12] Link reset or activation spares other interfaces
// [R13] Idle bit zero sent outside frames
// [R14] Wakeup sequence precedes every sent frame
// [R15] Timing from master edges, update only high
package swl_pkg;
	localparam int unsigned CLK_PERIOD_PS = 5000;
	// Longest high time of a zero bit; longer means one
	localparam int unsigned ZERO_HIGH_MAX_NS = 250;
	localparam int unsigned ZERO_HIGH_CYC = (ZERO_HIGH_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned WAKEUP_BITS = 8;
	localparam logic [7:0] RESERVED_BYTE = 8'h00;
	localparam int unsigned CNT_W = 8;
	typedef enum logic [1:0] {TX_IDLE, TX_WAKE, TX_DATA} tx_state_t;
	typedef struct packed {
		logic [7:0] data;
		logic valid;
	} byte_t;
	typedef struct packed {
		logic [2:0] sync;
		logic line;
		logic [CNT_W-1:0] hi_cnt;
		logic [7:0] rx_sh;
		logic [2:0] rx_bits;
		byte_t rx_out;
		tx_state_t tx_state;
		logic [3:0] tx_cnt;
		logic [7:0] tx_sh;
		logic draw;
		logic tx_ready;
	} link_state_t;
endpackage : swl_pkg

/* hw/swl_edge.sv */
`timescale 1ns/1ps
module swl_edge (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	// Line sample and current state
	input wire logic [2:0] sync,
	input wire logic line,
	// Edge flags
	output logic rise,
	output logic fall
);
	logic agree;
	// Only stages two and three are compared; stage one may be metastable
	assign agree = (sync[2] == sync[1]);
	assign rise = clk_en & agree & sync[2] & ~line; // R15
	assign fall = clk_en & agree & ~sync[2] & line; // R15

	a_edge_exclusive: assert property (@(posedge clk_sys) disable iff (!rst_b) // R15
		!(rise && fall))
		else $error("rise and fall flagged together");
endmodule : swl_edge

/* tb/swl_master_model.sv */
`timescale 1ns/1ps
module swl_master_model (
	// Link pin
	output logic master_voltage_signal,
	input wire logic slave_current_signal
);
	localparam int TICK = 64;
	initial master_voltage_signal = 1'b0;
	// One byte each way, b8 first; the high time carries each bit
	task automatic xfer_byte(input logic [7:0] d, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			master_voltage_signal = 1'b1;
			#100;
			r[i] = slave_current_signal;
			#((d[i] ? 6 : 2) * TICK - 100);
			master_voltage_signal = 1'b0;
			#((d[i] ? 2 : 6) * TICK);
		end
	endtask : xfer_byte
endmodule : swl_master_model

/* tb/single_wire_link_phy_principle_tb.sv */
`timescale 1ns/1ps
module single_wire_link_phy_principle_tb;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b1;
	logic master_voltage_signal, slave_current_signal, tx_ready, line_high, tx_last = 1'b0;
	swl_pkg::byte_t tx_in = '0;
	swl_pkg::byte_t rx_out;
	logic [7:0] rx_q = 8'h00, n_ready = 8'h00, n_low_draw = 8'h00;
	int n_mismatch = 0, num_checks = 0;
	always #2.5 clk_sys = ~clk_sys;
	swl_slave dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
		.master_voltage_signal(master_voltage_signal), .slave_current_signal(slave_current_signal),
		.tx_in(tx_in), .tx_last(tx_last), .tx_ready(tx_ready), .rx_out(rx_out),
		.line_high(line_high));
	swl_master_model m (.master_voltage_signal(master_voltage_signal),
		.slave_current_signal(slave_current_signal));
	// Capture receive pulses, send handshakes and any current draw with the line low
	always @(posedge clk_sys) begin
		if (rx_out.valid === 1'b1) rx_q <= rx_out.data;
		if (tx_ready === 1'b1) n_ready <= n_ready + 8'h01;
		if (slave_current_signal === 1'b1 && line_high !== 1'b1) n_low_draw <= n_low_draw + 8'h01;
	end
	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check_byte
	task automatic rx_only();
		logic [7:0] vals [3] = '{8'hA5, 8'hFF, 8'h01};
		logic [7:0] r;
		foreach (vals[k]) begin
			m.xfer_byte(vals[k], r);
			repeat (10) @(negedge clk_sys);
			check_byte("rx byte", vals[k], rx_q);
			check_byte("idle return", 8'h00, r);
		end
	endtask : rx_only
	task automatic tx_frame();
		logic [7:0] r;
		@(negedge clk_sys);
		tx_in = '{data: 8'hC3, valid: 1'b1};
		tx_last = 1'b1;
		m.xfer_byte(8'h00, r);
		check_byte("wakeup", 8'hAA, r);
		m.xfer_byte(8'h5A, r);
		check_byte("tx data", 8'hC3, r);
		@(negedge clk_sys);
		tx_in.valid = 1'b0;
		repeat (10) @(negedge clk_sys);
		check_byte("rx duplex", 8'h5A, rx_q);
		check_byte("tx_ready pulses", 8'h01, n_ready);
		m.xfer_byte(8'h00, r);
		check_byte("idle after frame", 8'h00, r);
	endtask : tx_frame
	task automatic reserved_fill();
		logic [7:0] r;
		@(negedge clk_sys);
		tx_in.valid = 1'b1;
		m.xfer_byte(8'h00, r);
		check_byte("wakeup again", 8'hAA, r);
		@(negedge clk_sys);
		tx_in.valid = 1'b0;
		m.xfer_byte(8'h00, r);
		check_byte("reserved byte", 8'h00, r);
	endtask : reserved_fill
	task automatic freeze_hold();
		logic [7:0] r;
		@(negedge clk_sys);
		clk_en = 1'b0;
		m.xfer_byte(8'hFF, r);
		check_byte("frozen return", 8'h00, r);
		check_byte("frozen line", 8'h00, {7'h00, line_high});
		@(negedge clk_sys);
		clk_en = 1'b1;
		repeat (10) @(negedge clk_sys);
		check_byte("frozen rx", 8'h00, rx_q);
	endtask : freeze_hold
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out
	initial begin
		repeat (20) @(negedge clk_sys);
		rst_b = 1'b1;
		repeat (4) @(negedge clk_sys);
		rx_only();
		tx_frame();
		reserved_fill();
		freeze_hold();
		check_byte("draw with line low", 8'h00, n_low_draw);
		close_out();
	end
endmodule : single_wire_link_phy_principle_tb
